// ==== rtl/lvx_aux_regs.sv ====
`timescale 1ns/10ps
`include "lvx_regs.svh"
// How it works
// - upper access on: upper half at B0000-BFFFF, lower stays A0000-AFFFF
// - upper access off: only lower 256K reachable by the CPU
// - page swap exchanges upper and lower page CPU addresses
// - overlay select zero: overlay pattern register ignored
// - overlay: 8-frame cycle, bit one shows upper, zero shows lower
// - mode 13H LCD: gray bit zero 64 shades, one 32; CRT unaffected
// - dither bit zero dithers 13H only; one disables; CRT unaffected
// - start 0..5 is first duplicated line; 6,7 no expand, centering off
// - CRT enabled disables graphics and text expansion
// - graphics expand needs enable, 18FH end, graphics mode, start 0..5
// - all graphics expansion conditions met forces autocentering off
// - text expand needs enable, height 0FH, 18FH end, text mode
// - text expand enable with CRT off forces autocentering off
// - three fixed primary revision bits read back
// - monitor sense inputs read live, unlatched
// - swap and page bits choose sprite group at A000H
// - sprite write goes to plane 1 when plane bit set, else 0
// - swap set: upper sprites at A000H, else at B000H
// - sprite write mode bypasses graphics controller write logic
// - overlay select one enables overlay, zero the extended page
module lvx_aux_regs (
  input  wire logic           ref_clk_in,
  input  wire logic           resetn_in,
  input  wire lvx_pkg::lvx_addr_t reg_addr_in,
  input  wire lvx_pkg::lvx_byte_t reg_wdata_in,
  input  wire logic           reg_wr_in,
  input  wire logic           reg_rd_in,
  output lvx_pkg::lvx_byte_t  reg_rdata_out,
  input  wire logic [2:0]     monitor_sense_inputs_in,
  input  wire logic           ext_page_enable_in,
  input  wire logic           mode13_in,
  input  wire logic           vsync_frame_in,
  input  wire logic [9:0]     vdisp_end_in,
  input  wire logic           graphics_mode_in,
  input  wire logic [4:0]     char_height_in,
  input  wire logic           auto_center_req_in,
  input  wire logic [3:0]     cpu_seg_in,
  output logic               cpu_mem_hit_out,
  output logic               cpu_upper_half_out,
  output logic               show_upper_out,
  output logic               ext_page_active_out,
  output logic               lcd_gray32_out,
  output logic               lcd_dither_out,
  output logic               gfx_expand_out,
  output logic [2:0]         gfx_expand_start_out,
  output logic               text_expand_out,
  output logic               auto_center_out,
  output logic               sprite_bypass_out,
  output logic               sprite_plane_out,
  output logic [1:0]         sprite_group_out,
  output logic               crt_enable_out
);
  import lvx_pkg::*;

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  lvx_byte_t overlay_frame_pattern;
  lvx_byte_t lcd_gray_and_expansion_control;
  lvx_byte_t sprite_write_control;
  lvx_byte_t ext_function_1;
  lvx_byte_t display_enable_register;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overlay_frame_pattern          <= `LVX_RST_BYTE;
      lcd_gray_and_expansion_control <= `LVX_RST_BYTE;
      sprite_write_control           <= `LVX_RST_BYTE;
      ext_function_1                 <= `LVX_RST_BYTE;
      display_enable_register        <= `LVX_RST_BYTE;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `LVX_OFS_OVERLAY: overlay_frame_pattern <= reg_wdata_in;
        `LVX_OFS_GRAYEXP: lcd_gray_and_expansion_control <= reg_wdata_in;
        `LVX_OFS_SPRITE:  sprite_write_control <= {4'h0, reg_wdata_in[3:0]};
        `LVX_OFS_XFUNC1:  ext_function_1 <= reg_wdata_in;
        `LVX_OFS_DISPEN:  display_enable_register <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // monitor sense synchroniser
  // -------------------------------------------------------------
  // third stage agreeing with second filters a single-cycle glitch
  logic [2:0] sense_s1;
  logic [2:0] sense_s2;
  logic [2:0] sense_s3;
  logic [2:0] sense_live;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sense_s1   <= 3'h7;
      sense_s2   <= 3'h7;
      sense_s3   <= 3'h7;
      sense_live <= 3'h7;
    end else begin
      sense_s1 <= monitor_sense_inputs_in;
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
      if (sense_s2 == sense_s3) begin
        sense_live <= sense_s3;
      end
    end
  end

  // -------------------------------------------------------------
  // read port
  // -------------------------------------------------------------
  lvx_byte_t next_rdata;

  always_comb begin
    unique case (reg_addr_in)
      `LVX_OFS_OVERLAY: next_rdata = overlay_frame_pattern;
      `LVX_OFS_GRAYEXP: next_rdata = lcd_gray_and_expansion_control;
      `LVX_OFS_REVMON:
        next_rdata = {`LVX_REV_PRIMARY, 2'b00, sense_live};
      `LVX_OFS_SPRITE:  next_rdata = sprite_write_control;
      `LVX_OFS_XFUNC1:  next_rdata = ext_function_1;
      `LVX_OFS_DISPEN:  next_rdata = display_enable_register;
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
    end
  end

  // -------------------------------------------------------------
  // decoded control bits
  // -------------------------------------------------------------
  logic       upper_en;
  logic       ovl_sel;
  logic       swap;
  logic       page_sel;
  logic       crt_on;
  logic [2:0] start;
  logic       start_ok;
  logic       vdisp_400;
  logic       gfx_ok;
  logic       text_ok;

  assign upper_en  = ext_function_1[`LVX_X1_UPPER];
  assign ovl_sel   = ext_function_1[`LVX_X1_OVLSEL];
  assign swap      = sprite_write_control[`LVX_SP_SWAP];
  assign page_sel  = sprite_write_control[`LVX_SP_PAGE];
  assign crt_on    = display_enable_register[`LVX_DE_CRT];
  assign start     = lcd_gray_and_expansion_control[`LVX_GE_START_LO +: 3];
  assign start_ok  = (start <= `LVX_START_MAX);
  assign vdisp_400 = (vdisp_end_in == `LVX_VDISP_400);
  assign gfx_ok    = lcd_gray_and_expansion_control[`LVX_GE_GFX]
                     && vdisp_400 && graphics_mode_in
                     && start_ok && !crt_on;
  assign text_ok   = lcd_gray_and_expansion_control[`LVX_GE_TEXT]
                     && (char_height_in == `LVX_CHAR_16PT)
                     && vdisp_400 && !graphics_mode_in
                     && !crt_on;

  // -------------------------------------------------------------
  // CPU window decode
  // -------------------------------------------------------------
  // segment A is lower page, B is upper page unless swapped
  logic seg_a;
  logic seg_b;
  assign seg_a = (cpu_seg_in == 4'hA);
  assign seg_b = (cpu_seg_in == 4'hB);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cpu_mem_hit_out    <= 1'b0;
      cpu_upper_half_out <= 1'b0;
    end else begin
      cpu_mem_hit_out    <= seg_a || (seg_b && upper_en);
      cpu_upper_half_out <= upper_en && (swap ? seg_a : seg_b);
    end
  end

  // -------------------------------------------------------------
  // overlay frame sequencer
  // -------------------------------------------------------------
  logic [2:0] frame_idx;
  logic       vs_d;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      frame_idx <= 3'h0;
      vs_d      <= 1'b0;
    end else begin
      vs_d <= vsync_frame_in;
      if (vsync_frame_in && !vs_d) begin
        frame_idx <= frame_idx + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      show_upper_out      <= 1'b0;
      ext_page_active_out <= 1'b0;
    end else begin
      show_upper_out      <= ovl_sel
                             && overlay_frame_pattern[frame_idx];
      ext_page_active_out <= !ovl_sel && ext_page_enable_in;
    end
  end

  // -------------------------------------------------------------
  // LCD gray, dither and expansion outputs
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lcd_gray32_out       <= 1'b0;
      lcd_dither_out       <= 1'b0;
      gfx_expand_out       <= 1'b0;
      gfx_expand_start_out <= 3'h0;
      text_expand_out      <= 1'b0;
      auto_center_out      <= 1'b0;
      crt_enable_out       <= 1'b0;
    end else begin
      lcd_gray32_out  <= mode13_in && !crt_on
                         && lcd_gray_and_expansion_control[`LVX_GE_GRAY32];
      lcd_dither_out  <= mode13_in && !crt_on
                         && !lcd_gray_and_expansion_control[`LVX_GE_DITHER];
      gfx_expand_out       <= gfx_ok;
      gfx_expand_start_out <= start;
      text_expand_out      <= text_ok;
      // start 6/7 with the rest met still blocks centering
      auto_center_out <= auto_center_req_in
        && !(lcd_gray_and_expansion_control[`LVX_GE_GFX] && vdisp_400
             && graphics_mode_in && !crt_on)
        && !(lcd_gray_and_expansion_control[`LVX_GE_TEXT]
             && !crt_on);
      crt_enable_out <= crt_on;
    end
  end

  // -------------------------------------------------------------
  // sprite write steering
  // -------------------------------------------------------------
  // sprites 0..255 overlap standard memory; software avoids them
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sprite_bypass_out <= 1'b0;
      sprite_plane_out  <= 1'b0;
      sprite_group_out  <= 2'h0;
    end else begin
      sprite_bypass_out <= sprite_write_control[`LVX_SP_WRMODE];
      sprite_plane_out  <= sprite_write_control[`LVX_SP_PLANE];
      sprite_group_out  <= {swap, page_sel};
    end
  end

endmodule // lvx_aux_regs

// ==== shared/lvx_pkg.sv ====
package lvx_pkg;
  typedef logic [7:0] lvx_byte_t;
  typedef logic [3:0] lvx_addr_t;
endpackage

// ==== shared/lvx_regs.svh ====
`ifndef LVX_REGS_SVH
`define LVX_REGS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LVX_OFS_OVERLAY   4'h6
`define LVX_OFS_GRAYEXP   4'h7
`define LVX_OFS_REVMON    4'h8
`define LVX_OFS_SPRITE    4'h9
`define LVX_OFS_XFUNC1    4'h5
`define LVX_OFS_DISPEN    4'hB
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LVX_X1_UPPER      0
`define LVX_X1_OVLSEL     1
`define LVX_GE_TEXT       0
`define LVX_GE_GFX        1
`define LVX_GE_START_LO   2
`define LVX_GE_DITHER     6
`define LVX_GE_GRAY32     7
`define LVX_SP_WRMODE     0
`define LVX_SP_SWAP       1
`define LVX_SP_PLANE      2
`define LVX_SP_PAGE       3
`define LVX_DE_CRT        1
// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define LVX_RST_BYTE      8'h00
`define LVX_REV_PRIMARY   3'h7
`define LVX_VDISP_400     10'h18F
`define LVX_CHAR_16PT     5'h0F
`define LVX_START_MAX     3'h5
`endif

// ==== testbench/lcd_vga_aux_display_extensions_bench.sv ====
`timescale 1ns/10ps
module lcd_vga_aux_display_extensions_bench;
  import lvx_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, vsync = 1'b0, gfx = 1'b1, acr = 1'b1;
  logic extp = 1'b1, mode13 = 1'b1, wr, rd;
  logic [9:0] vde = 10'h18F;
  logic [4:0] chh = 5'h0F;
  logic [3:0] seg = 4'hA;
  logic [2:0] sense = 3'h5, gst;
  logic [1:0] grp;
  logic hit, upper, show, extact, gray, dith, gexp, texp, acen, byp, plane;
  logic crt;
  lvx_addr_t addr;
  lvx_byte_t wdata, rdata, v;
  int fails = 0, cmp_count = 0;
  lvx_byte_t exp_rst [5] = '{8'h00, 8'h00, 8'hE5, 8'h00, 8'h00};
  lvx_addr_t rst_adr [5] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hC};
  lvx_aux_regs uut (.ref_clk_in(ref_clk), .resetn_in(resetn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .monitor_sense_inputs_in(sense),
    .ext_page_enable_in(extp), .mode13_in(mode13), .vsync_frame_in(vsync),
    .vdisp_end_in(vde), .graphics_mode_in(gfx), .char_height_in(chh),
    .auto_center_req_in(acr), .cpu_seg_in(seg), .cpu_mem_hit_out(hit),
    .cpu_upper_half_out(upper), .show_upper_out(show),
    .ext_page_active_out(extact), .lcd_gray32_out(gray),
    .lcd_dither_out(dith), .gfx_expand_out(gexp),
    .gfx_expand_start_out(gst), .text_expand_out(texp),
    .auto_center_out(acen), .sprite_bypass_out(byp),
    .sprite_plane_out(plane), .sprite_group_out(grp), .crt_enable_out(crt));
  lvx_host_model host (.ref_clk_in(ref_clk), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd));
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input string n, input lvx_byte_t s, input lvx_byte_t e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // outputs trail a register write by two edges
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task set(input lvx_addr_t a, input lvx_byte_t d);
    host.wr_reg(a, d);
    settle();
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100_000;
    fails++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rst_adr[i]) begin
      host.rd_reg(rst_adr[i], v);
      chk("reset", v, exp_rst[i]);
    end
    set(4'h8, 8'h00);
    @(posedge ref_clk) sense <= 3'h2;
    settle();
    settle();
    host.rd_reg(4'h8, v);
    chk("sense", v, 8'hE2);
    set(4'h6, 8'h4D);
    host.rd_reg(4'h6, v);
    chk("pattern", v, 8'h4D);
    $display("test registers done");
    set(4'h5, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) seg <= i[0] ? 4'hB : 4'hA;
      set(4'h9, {4'h0, i[0], i[0], i[1], 1'b1});
      chk("map", {hit, upper, byp, plane, grp, crt, texp},
        {2'h2 | 2'(i[0] ^ i[1]), 1'b1, i[0], i[1], i[0], 2'h0});
    end
    set(4'h5, 8'h00);
    set(4'h9, 8'h00);
    chk("off", {hit, byp, 6'h00}, 8'h00);
    $display("test map done");
    set(4'h5, 8'h02);
    for (int k = 0; k < 16; k++) begin
      chk("ovl", {7'h00, show}, (8'h4D >> (k % 8)) & 8'h01);
      @(posedge ref_clk) vsync <= 1'b1;
      @(posedge ref_clk) vsync <= 1'b0;
      settle();
    end
    set(4'h6, 8'hFF);
    set(4'h5, 8'h00);
    chk("page", {show, extact, 6'h00}, 8'h40);
    $display("test overlay done");
    for (int s = 0; s < 8; s++) begin
      set(4'h7, 8'(s << 2) | 8'h02);
      chk("gexp", {gexp, acen, 3'h0, gst}, {s < 6, 4'h0, 3'(s)});
    end
    set(4'h7, 8'h80);
    chk("lcd", {gray, dith, acen, 5'h00}, 8'hE0);
    @(posedge ref_clk) mode13 <= 1'b0;
    settle();
    chk("lcd13", {gray, dith, 6'h00}, 8'h00);
    @(posedge ref_clk) mode13 <= 1'b1;
    set(4'h7, 8'h40);
    chk("lcd", {gray, dith, acen, 5'h00}, 8'h20);
    @(posedge ref_clk) vde <= 10'h18E;
    set(4'h7, 8'h02);
    chk("nogexp", {gexp, acen, 6'h00}, 8'h40);
    @(posedge ref_clk) vde <= 10'h18F;
    gfx <= 1'b0;
    set(4'h7, 8'h01);
    chk("text", {texp, acen, 6'h00}, 8'h80);
    @(posedge ref_clk) chh <= 5'h0E;
    settle();
    chk("notext", {texp, acen, 6'h00}, 8'h00);
    @(posedge ref_clk) chh <= 5'h0F;
    set(4'hB, 8'h02);
    chk("crt", {texp, crt, acen, 5'h00}, 8'h60);
    $display("test expansion done");
    end_of_test();
  end
endmodule // lcd_vga_aux_display_extensions_bench

// ==== testbench/lvx_aux_checker.sv ====
`timescale 1ns/10ps
`include "lvx_regs.svh"
module lvx_aux_checker (
  input wire logic               ref_clk_in,
  input wire logic               resetn_in,
  input wire lvx_pkg::lvx_addr_t reg_addr_in,
  input wire logic               reg_rd_in,
  input wire lvx_pkg::lvx_byte_t reg_rdata_out,
  input wire logic [9:0]         vdisp_end_in,
  input wire logic               graphics_mode_in,
  input wire logic [4:0]         char_height_in,
  input wire logic [3:0]         cpu_seg_in,
  input wire logic               cpu_mem_hit_out,
  input wire logic               show_upper_out,
  input wire logic               ext_page_active_out,
  input wire logic               gfx_expand_out,
  input wire logic [2:0]         gfx_expand_start_out,
  input wire logic               text_expand_out,
  input wire logic               auto_center_out,
  input wire logic               crt_enable_out
);
  import lvx_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_lower_always_hit: assert property (
    $past(resetn_in) && $past(cpu_seg_in) == 4'hA |-> cpu_mem_hit_out)
    else $error("low miss");
  chk_crt_no_expand: assert property (
    crt_enable_out |-> !gfx_expand_out && !text_expand_out)
    else $error("expand with crt");
  chk_gfx_no_center: assert property (
    gfx_expand_out |-> !auto_center_out) else $error("gfx centering");
  chk_text_no_center: assert property (
    text_expand_out |-> !auto_center_out) else $error("text centering");
  chk_gfx_expand_cond: assert property (
    gfx_expand_out |-> $past(vdisp_end_in) == `LVX_VDISP_400
      && $past(graphics_mode_in) && gfx_expand_start_out <= 3'h5)
    else $error("gfx expand cond");
  chk_text_expand_cond: assert property (
    text_expand_out |-> $past(vdisp_end_in) == `LVX_VDISP_400
      && !$past(graphics_mode_in) && $past(char_height_in) == 5'h0F)
    else $error("text expand cond");
  chk_revision_bits: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == 4'h8
      |-> reg_rdata_out[7:3] == 5'h1C) else $error("revision bits");
  chk_overlay_excl: assert property (
    !(show_upper_out && ext_page_active_out)) else $error("overlay and page");
  cover property (gfx_expand_out);
  cover property (text_expand_out);
  cover property (show_upper_out);
endmodule // lvx_aux_checker
bind lvx_aux_regs lvx_aux_checker u_chk (.ref_clk_in, .resetn_in,
  .reg_addr_in, .reg_rd_in, .reg_rdata_out, .vdisp_end_in,
  .graphics_mode_in, .char_height_in, .cpu_seg_in, .cpu_mem_hit_out,
  .show_upper_out, .ext_page_active_out, .gfx_expand_out,
  .gfx_expand_start_out, .text_expand_out, .auto_center_out,
  .crt_enable_out);

// ==== testbench/lvx_host_model.sv ====
`timescale 1ns/10ps
module lvx_host_model (
  input  wire logic               ref_clk_in,
  input  wire lvx_pkg::lvx_byte_t reg_rdata_in,
  output lvx_pkg::lvx_addr_t      reg_addr_out,
  output lvx_pkg::lvx_byte_t      reg_wdata_out,
  output logic                    reg_wr_out,
  output logic                    reg_rd_out
);
  import lvx_pkg::*;
  // never stores sprite data, so sprites 0 to 255 stay untouched
  initial begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  task wr_reg(input lvx_addr_t a, input lvx_byte_t d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd_reg(input lvx_addr_t a, output lvx_byte_t d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    #1 d = reg_rdata_in;
  endtask
endmodule // lvx_host_model
